/* File: rtl/ltd_core.v */
// Purpose: literal and table op decode/execute with apb register view
// Assumes: fetch, program and data memory on pclk; pins asynchronous
// Notes: one instruction cycle is four pclk phases
// Functional notes
// - add immediate updates all five flags
// - and immediate, zero and negative only
// - or immediate, zero and negative only
// - xor immediate, zero and negative only
// - immediate minus accumulator, all five flags
// - load accumulator immediate, no flags
// - multiply immediate, one cycle, no flags
// - load low bank nibble, no flags
// - return with immediate, two cycles
// - two-word load of twelve-bit pointer
// - table read with four pointer modes
// - table write with four pointer modes
// - launched memory write runs until terminated
// - lone second word executes as nop
// - pc change spends nop second cycle
// - port read-modify-write reads the pins
// - timer zero write clears assigned prescaler
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "ltd_consts.vh"
module ltd_core (
   // apb slave
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output wire pready,
   output reg [31:0] prdata,
   output reg pslverr,
   // instruction fetch
   input wire instr_valid,
   input wire [15:0] instr_word,
   output wire instr_ready,
   input wire ext_two_cycle,
   output reg ret_req,
   output reg nop_cycle,
   // program memory table port
   output reg [21:0] pm_addr,
   output reg pm_rd_req,
   input wire [7:0] pm_rdata,
   output reg pm_wr_req,
   output reg [7:0] pm_wdata,
   input wire pm_wr_done,
   output reg pm_wr_busy,
   // data memory read-modify-write hooks
   input wire [11:0] rd_addr,
   input wire [7:0] rd_latch,
   output reg [7:0] rd_data,
   input wire dw_valid,
   input wire [11:0] dw_addr,
   output reg prescaler_clr,
   // port pins
   input wire [7:0] port_pins
);
   // phase states
   localparam PH_Q1 = 4'h1;
   localparam PH_Q2 = 4'h2;
   localparam PH_Q3 = 4'h4;
   localparam PH_Q4 = 4'h8;
   // op classes
   localparam K_NOP = 4'h0;
   localparam K_ADD = 4'h1;
   localparam K_AND = 4'h2;
   localparam K_IOR = 4'h3;
   localparam K_XOR = 4'h4;
   localparam K_SUB = 4'h5;
   localparam K_MOV = 4'h6;
   localparam K_MUL = 4'h7;
   localparam K_BANK = 4'h8;
   localparam K_RET = 4'h9;
   localparam K_LOAD_POINTER_IMMEDIATE_OP = 4'hA;
   localparam K_TRD = 4'hB;
   localparam K_TWR = 4'hC;
   reg [3:0] ph_q;
   reg cyc2_q;
   reg [15:0] ir_q;
   reg [7:0] lit_q;
   reg [7:0] lit2_q;
   reg [7:0] acc_q;
   reg [4:0] flags_q;
   reg [3:0] bank_q;
   reg [11:0] ptr0_q;
   reg [11:0] ptr1_q;
   reg [11:0] ptr2_q;
   reg [21:0] tptr_q;
   reg [7:0] tlat_q;
   reg [15:0] prod_q;
   reg [1:0] ctrl_q;
   reg [7:0] res_q;
   reg [4:0] fres_q;
   reg [7:0] pin_s1_q;
   reg [7:0] pin_s2_q;
   // ----------------------------------------
   // decode
   // ----------------------------------------
   // classify one word; anything not ours reads as nop
   function [3:0] ltd_class;
      input [15:0] w;
      begin
         case (w[15:8])
            `LTD_OP_ADD: ltd_class = K_ADD;
            `LTD_OP_AND: ltd_class = K_AND;
            `LTD_OP_IOR: ltd_class = K_IOR;
            `LTD_OP_XOR: ltd_class = K_XOR;
            `LTD_OP_SUB: ltd_class = K_SUB;
            `LTD_OP_MOV: ltd_class = K_MOV;
            `LTD_OP_MUL: ltd_class = K_MUL;
            `LTD_OP_RET: ltd_class = K_RET;
            `LTD_OP_LOAD_POINTER_IMMEDIATE_OP: ltd_class = (w[7:6] == 2'h0) ? K_LOAD_POINTER_IMMEDIATE_OP : K_NOP;
            default: begin
               if (w[15:4] == `LTD_OP_BANK)
                  ltd_class = K_BANK;
               else if (w[15:4] == `LTD_OP_TBL && w[3])
                  ltd_class = w[2] ? K_TWR : K_TRD;
               else
                  ltd_class = K_NOP;
            end
         endcase
      end
   endfunction
   wire [3:0] cls = ltd_class(ir_q);
   wire [1:0] tmode = ir_q[1:0];
   wire two_cyc = (cls == K_RET) || (cls == K_LOAD_POINTER_IMMEDIATE_OP) ||
      (cls == K_TRD) || (cls == K_TWR);
   // pre-increment moves the pointer before the access
   wire [21:0] tptr_eff = (tmode == 2'h3) ? tptr_q + 22'h000001 : tptr_q;
   // word taken at decode; the load_pointer_immediate_op second word is taken too
   assign instr_ready = (ph_q == PH_Q1) &&
      (!cyc2_q || cls == K_LOAD_POINTER_IMMEDIATE_OP);
   assign pready = 1'b1;
   // ----------------------------------------
   // arithmetic
   // ----------------------------------------
   // subtract is literal plus inverted accumulator plus one
   wire is_sub = (cls == K_SUB);
   wire [7:0] opb = is_sub ? ~acc_q : acc_q;
   wire [8:0] sum = {1'b0, lit_q} + {1'b0, opb} + {8'h00, is_sub};
   wire [4:0] nib = {1'b0, lit_q[3:0]} + {1'b0, opb[3:0]} +
      {4'h0, is_sub};
   wire ovf = (lit_q[7] == opb[7]) && (sum[7] != lit_q[7]);
   reg [7:0] alu;
   reg [4:0] fnew;
   always @* begin
      alu = sum[7:0];
      fnew = flags_q;
      case (cls)
         K_ADD, K_SUB: begin
            fnew[`LTD_F_C] = sum[8];
            fnew[`LTD_F_DC] = nib[4];
            fnew[`LTD_F_OV] = ovf;
         end
         K_AND: alu = lit_q & acc_q;
         K_IOR: alu = lit_q | acc_q;
         K_XOR: alu = lit_q ^ acc_q;
         default: alu = lit_q;
      endcase
      // logic and arithmetic ops share zero and negative
      if (cls == K_ADD || cls == K_SUB || cls == K_AND ||
         cls == K_IOR || cls == K_XOR) begin
         fnew[`LTD_F_Z] = (alu == 8'h00);
         fnew[`LTD_F_N] = alu[7];
      end
   end
   // ----------------------------------------
   // phase sequencer
   // ----------------------------------------
   // phases run free so instruction timing never drifts
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ph_q <= PH_Q1;
         cyc2_q <= 1'b0;
         ir_q <= `LTD_OP_NOP;
         lit_q <= 8'h00;
         lit2_q <= 8'h00;
         res_q <= 8'h00;
         fres_q <= 5'h00;
      end else begin
         case (ph_q)
            PH_Q1: begin
               ph_q <= PH_Q2;
               if (!cyc2_q)
                  ir_q <= instr_valid ? instr_word : `LTD_OP_NOP;
               else if (cls == K_LOAD_POINTER_IMMEDIATE_OP && instr_valid &&
                  instr_word[15:8] == `LTD_OP_SECOND)
                  lit2_q <= instr_word[7:0];
            end
            PH_Q2: begin
               ph_q <= PH_Q3;
               lit_q <= ir_q[7:0];
            end
            PH_Q3: begin
               ph_q <= PH_Q4;
               res_q <= alu;
               fres_q <= fnew;
            end
            PH_Q4: begin
               ph_q <= PH_Q1;
               // a pc change earns a second, empty cycle
               cyc2_q <= !cyc2_q && (two_cyc || ext_two_cycle);
            end
            default: ph_q <= PH_Q1;
         endcase
      end
   end
   // ----------------------------------------
   // architectural registers
   // ----------------------------------------
   // apb writes first; an execution write in the same clock wins
   wire apb_wr = psel && penable && pwrite;
   wire ex_q4 = (ph_q == PH_Q4) && !cyc2_q;
   wire ex2_q1 = (ph_q == PH_Q1) && cyc2_q;
   wire ex2_q4 = (ph_q == PH_Q4) && cyc2_q;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_q <= 8'h00;
         flags_q <= 5'h00;
         bank_q <= 4'h0;
         ptr0_q <= 12'h000;
         ptr1_q <= 12'h000;
         ptr2_q <= 12'h000;
         tptr_q <= 22'h000000;
         tlat_q <= 8'h00;
         prod_q <= 16'h0000;
         ctrl_q <= `LTD_CTRL_RST;
      end else begin
         if (apb_wr) begin
            case (paddr)
               `LTD_A_ACC: acc_q <= pwdata[7:0];
               `LTD_A_FLAGS: flags_q <= pwdata[4:0];
               `LTD_A_BANK: bank_q <= pwdata[3:0];
               `LTD_A_PTR0: ptr0_q <= pwdata[11:0];
               `LTD_A_PTR1: ptr1_q <= pwdata[11:0];
               `LTD_A_PTR2: ptr2_q <= pwdata[11:0];
               `LTD_A_TPTR: tptr_q <= pwdata[21:0];
               `LTD_A_TLAT: tlat_q <= pwdata[7:0];
               `LTD_A_PROD: prod_q <= pwdata[15:0];
               `LTD_A_CTRL: ctrl_q <= pwdata[1:0];
               default: ;
            endcase
         end
         if (ex_q4) begin
            case (cls)
               K_ADD, K_SUB, K_AND, K_IOR, K_XOR: begin
                  acc_q <= res_q;
                  flags_q <= fres_q;
               end
               K_MOV, K_RET: acc_q <= res_q;
               K_MUL: prod_q <= {8'h00, lit_q} * {8'h00, acc_q};
               K_BANK: bank_q <= ir_q[3:0];
               default: ;
            endcase
         end
         // pre-increment lands before the memory access
         if (ex2_q1 && (cls == K_TRD || cls == K_TWR))
            tptr_q <= tptr_eff;
         if (ex2_q4) begin
            if (cls == K_TRD || cls == K_TWR) begin
               if (tmode == 2'h1)
                  tptr_q <= tptr_q + 22'h000001;
               else if (tmode == 2'h2)
                  tptr_q <= tptr_q - 22'h000001;
            end
            if (cls == K_TRD)
               tlat_q <= pm_rdata;
            if (cls == K_LOAD_POINTER_IMMEDIATE_OP) begin
               case (ir_q[5:4])
                  2'h0: ptr0_q <= {ir_q[3:0], lit2_q};
                  2'h1: ptr1_q <= {ir_q[3:0], lit2_q};
                  2'h2: ptr2_q <= {ir_q[3:0], lit2_q};
                  default: ;
               endcase
            end
         end
      end
   end
   // ----------------------------------------
   // program memory and flow strobes
   // ----------------------------------------
   // read data is taken at the end of the second cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pm_addr <= 22'h000000;
         pm_rd_req <= 1'b0;
         pm_wr_req <= 1'b0;
         pm_wdata <= 8'h00;
         pm_wr_busy <= 1'b0;
         ret_req <= 1'b0;
         nop_cycle <= 1'b0;
      end else begin
         pm_rd_req <= ex2_q1 && (cls == K_TRD);
         pm_wr_req <= ex2_q1 && (cls == K_TWR);
         if (ex2_q1 && (cls == K_TRD || cls == K_TWR))
            pm_addr <= tptr_eff;
         pm_wdata <= tlat_q;
         // long write outlives the instruction; launch beats done
         if (ex2_q1 && cls == K_TWR && ctrl_q[`LTD_C_LONGWR])
            pm_wr_busy <= 1'b1;
         else if (pm_wr_done)
            pm_wr_busy <= 1'b0;
         ret_req <= ex_q4 && (cls == K_RET);
         nop_cycle <= (ph_q == PH_Q4) ? (!cyc2_q &&
            (two_cyc || ext_two_cycle)) : nop_cycle;
      end
   end
   // ----------------------------------------
   // read-modify-write side effects
   // ----------------------------------------
   // two flops before the pins are read by anything
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s1_q <= 8'h00;
         pin_s2_q <= 8'h00;
         rd_data <= 8'h00;
         prescaler_clr <= 1'b0;
      end else begin
         pin_s1_q <= port_pins;
         pin_s2_q <= pin_s1_q;
         // port reads see pin levels, not the output latch
         rd_data <= (rd_addr == `LTD_PORT_ADDR) ?
            pin_s2_q : rd_latch;
         prescaler_clr <= dw_valid && (dw_addr == `LTD_TIMER_ZERO_COUNT_ADDR) &&
            ctrl_q[`LTD_C_PSC];
      end
   end
   // ----------------------------------------
   // apb read path
   // ----------------------------------------
   // data captured in setup so access needs no wait state
   reg [31:0] rmux;
   reg rhit;
   always @* begin
      rmux = 32'h00000000;
      rhit = 1'b1;
      case (paddr)
         `LTD_A_ACC: rmux = {24'h000000, acc_q};
         `LTD_A_FLAGS: rmux = {27'h0000000, flags_q};
         `LTD_A_BANK: rmux = {28'h0000000, bank_q};
         `LTD_A_PTR0: rmux = {20'h00000, ptr0_q};
         `LTD_A_PTR1: rmux = {20'h00000, ptr1_q};
         `LTD_A_PTR2: rmux = {20'h00000, ptr2_q};
         `LTD_A_TPTR: rmux = {10'h000, tptr_q};
         `LTD_A_TLAT: rmux = {24'h000000, tlat_q};
         `LTD_A_PROD: rmux = {16'h0000, prod_q};
         `LTD_A_CTRL: rmux = {30'h00000000, ctrl_q};
         `LTD_A_STAT: rmux = {26'h0000000, cyc2_q, pm_wr_busy, ph_q};
         default: rhit = 1'b0;
      endcase
   end
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         prdata <= pwrite ? 32'h00000000 : rmux;
         pslverr <= !rhit;
      end
   end
endmodule
`default_nettype wire

/* File: rtl/ltd_consts.vh */
// Purpose: constants for the literal and table op decoder
// Assumes: included by its bare name
// Notes: definitions only
`ifndef LTD_CONSTS_VH
`define LTD_CONSTS_VH
// ----------------------------------------
// opcode high bytes, twelve-bit prefixes and the nop word
// ----------------------------------------
`define LTD_OP_ADD 8'h0F
`define LTD_OP_AND 8'h0B
`define LTD_OP_IOR 8'h09
`define LTD_OP_XOR 8'h0A
`define LTD_OP_SUB 8'h08
`define LTD_OP_MOV 8'h0E
`define LTD_OP_MUL 8'h0D
`define LTD_OP_RET 8'h0C
`define LTD_OP_LOAD_POINTER_IMMEDIATE_OP 8'hEE
`define LTD_OP_BANK 12'h010
`define LTD_OP_TBL 12'h000
`define LTD_OP_SECOND 8'hF0
`define LTD_OP_NOP 16'h0000
// ----------------------------------------
// flag bit positions
// ----------------------------------------
`define LTD_F_C 0
`define LTD_F_DC 1
`define LTD_F_Z 2
`define LTD_F_OV 3
`define LTD_F_N 4
// ----------------------------------------
// apb byte offsets
// ----------------------------------------
`define LTD_A_ACC 8'h00
`define LTD_A_FLAGS 8'h04
`define LTD_A_BANK 8'h08
`define LTD_A_PTR0 8'h0C
`define LTD_A_PTR1 8'h10
`define LTD_A_PTR2 8'h14
`define LTD_A_TPTR 8'h18
`define LTD_A_TLAT 8'h1C
`define LTD_A_PROD 8'h20
`define LTD_A_CTRL 8'h24
`define LTD_A_STAT 8'h28
// ----------------------------------------
// control bits and data addresses
// ----------------------------------------
`define LTD_C_PSC 0
`define LTD_C_LONGWR 1
`define LTD_PORT_ADDR 12'hF80
`define LTD_TIMER_ZERO_COUNT_ADDR 12'hFD6
`define LTD_CTRL_RST 2'h0
`endif

/* File: bench/ltd_mem_model.sv */
// Purpose: program and data memory partner for the literal/table decoder
// Assumes: table data is wanted from one to three clocks after a request
// Notes: slow stretches the finish of a launched program memory write
`timescale 1ns/1ps
`default_nettype none
module ltd_mem_model (
   // clock and pace
   input wire logic pclk,
   input wire logic slow,
   // table port
   input wire logic [21:0] pm_addr,
   input wire logic pm_rd_req,
   output logic [7:0] pm_rdata,
   input wire logic pm_wr_req,
   input wire logic [7:0] pm_wdata,
   output logic pm_wr_done,
   // data memory read port
   input wire logic [11:0] rd_addr,
   output logic [7:0] rd_latch
);
   logic [1:0] rd_cnt = 2'h0;
   logic [4:0] wr_cnt = 5'h0;
   logic [7:0] rd_q = 8'h00;
   logic [21:0] wa = 22'h0;
   logic [7:0] wd = 8'h00;
   // ----------------------------------------
   // table service
   // ----------------------------------------
   // read data holds four clocks, then toggles so stale data never matches
   always @(posedge pclk) begin
      pm_wr_done <= 1'b0;
      if (pm_rd_req) begin
         rd_q <= pm_addr[7:0] ^ 8'hA5;
         rd_cnt <= 2'h3;
      end else if (rd_cnt != 2'h0) begin
         rd_cnt <= rd_cnt - 2'h1;
      end else begin
         rd_q <= ~rd_q;
      end
      // write runs on for a while before the cell reports it finished
      if (pm_wr_req) begin
         wa <= pm_addr;
         wd <= pm_wdata;
         wr_cnt <= slow ? 5'h14 : 5'h2;
      end else if (wr_cnt == 5'h1) begin
         pm_wr_done <= 1'b1;
         wr_cnt <= 5'h0;
      end else if (wr_cnt != 5'h0) begin
         wr_cnt <= wr_cnt - 5'h1;
      end
   end
   assign pm_rdata = rd_q;
   // data memory answers combinationally from the address
   assign rd_latch = rd_addr[7:0] ^ 8'h3C;
endmodule
`default_nettype wire

/* File: bench/ltd_core_chk.sv */
// Purpose: port-level assertions for the literal and table op decoder
// Assumes: single pclk domain, presetn low clears everything
// Notes: attached by bind from the bench top
`timescale 1ns/1ps
`default_nettype none
`include "ltd_consts.vh"
module ltd_core_chk (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // watched ports
   input wire logic instr_ready,
   input wire logic ret_req,
   input wire logic nop_cycle,
   input wire logic pm_rd_req,
   input wire logic pm_wr_req,
   input wire logic pm_wr_done,
   input wire logic pm_wr_busy,
   input wire logic [11:0] rd_addr,
   input wire logic [7:0] rd_latch,
   input wire logic [7:0] rd_data,
   input wire logic dw_valid,
   input wire logic [11:0] dw_addr,
   input wire logic prescaler_clr,
   input wire logic [7:0] port_pins
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ----------------------------------------
   // sequences and properties
   // ----------------------------------------
   sequence s_nop_cycle;
      nop_cycle [*4] ##1 !nop_cycle;
   endsequence
   sequence s_rd_quiet;
      !pm_rd_req [*7];
   endsequence
   property p_ret_pulse;
      ret_req |=> !ret_req;
   endproperty
   a_ret_pulse: assert property (p_ret_pulse)
      else $error("return request longer than one clock");
   property p_nop_len;
      $rose(nop_cycle) |-> s_nop_cycle;
   endproperty
   a_nop_len: assert property (p_nop_len)
      else $error("nop cycle not four clocks");
   property p_rd_once;
      pm_rd_req |=> s_rd_quiet;
   endproperty
   a_rd_once: assert property (p_rd_once)
      else $error("table read requested twice in one op");
   property p_wr_once;
      pm_wr_req |=> !pm_wr_req [*7];
   endproperty
   a_wr_once: assert property (p_wr_once)
      else $error("table write requested twice in one op");
   property p_fetch_rate;
      instr_ready |=> !instr_ready [*3];
   endproperty
   a_fetch_rate: assert property (p_fetch_rate)
      else $error("word taken faster than one per four clocks");
   property p_busy_hold;
      pm_wr_busy && !pm_wr_done |=> pm_wr_busy;
   endproperty
   a_busy_hold: assert property (p_busy_hold)
      else $error("long write dropped before it finished");
   property p_busy_end;
      pm_wr_busy && pm_wr_done |=> !pm_wr_busy || pm_wr_req;
   endproperty
   a_busy_end: assert property (p_busy_end)
      else $error("long write busy after finish");
   property p_tmr_clr;
      prescaler_clr |-> $past(dw_valid) && $past(dw_addr) == `LTD_TIMER_ZERO_COUNT_ADDR;
   endproperty
   a_tmr_clr: assert property (p_tmr_clr)
      else $error("prescaler cleared without a timer write");
   property p_rmw_latch;
      rd_addr != `LTD_PORT_ADDR |=> rd_data == $past(rd_latch);
   endproperty
   a_rmw_latch: assert property (p_rmw_latch)
      else $error("read data not taken from the latch");
   property p_rmw_pins;
      rd_addr == `LTD_PORT_ADDR && $stable(port_pins) &&
         port_pins == $past(port_pins, 2) |=> rd_data == $past(port_pins);
   endproperty
   a_rmw_pins: assert property (p_rmw_pins)
      else $error("port read data not taken from the pins");
endmodule
`default_nettype wire

/* File: bench/literal_and_table_op_decoder_test.sv */
// Purpose: self-checking bench for the literal and table op decoder
// Assumes: words fed at phase one, results read back over apb
// Notes: the second-cycle request from other decoders is held low except for one forced one-cycle op
`timescale 1ns/1ps
`default_nettype none
`include "ltd_consts.vh"
module literal_and_table_op_decoder_test;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic pready, pslverr, instr_ready, ret_req, nop_cycle, prescaler_clr;
   logic [31:0] prdata, rv;
   logic instr_valid = 1'b0;
   logic [15:0] instr_word = 16'h0000;
   logic ext_two_cycle = 1'b0;
   logic [21:0] pm_addr, tp, ta;
   logic pm_rd_req, pm_wr_req, pm_wr_done, pm_wr_busy;
   logic [7:0] pm_rdata, pm_wdata, rd_latch, rd_data;
   logic [11:0] rd_addr = 12'h000;
   logic dw_valid = 1'b0;
   logic [11:0] dw_addr = 12'h000;
   logic [7:0] port_pins = 8'h00;
   logic slow = 1'b0;
   int n_fail = 0;
   int tests_run = 0;
   int n_ret = 0;
   int n_nop = 0;
   int gap, k;
   // literal ops with accumulator and flags expected after each
   logic [15:0] lit_w [11] = '{16'h0E10, 16'h0F15, 16'h0FF0, 16'h0B5F,
      16'h0980, 16'h0A95, 16'h0E7F, 16'h0801, 16'h0F7F, 16'h0F7F, 16'h0D03};
   logic [7:0] lit_a [11] = '{8'h10, 8'h25, 8'h15, 8'h15, 8'h95, 8'h00,
      8'h7F, 8'h82, 8'h01, 8'h80, 8'h80};
   logic [4:0] lit_f [11] = '{5'h00, 5'h00, 5'h01, 5'h01, 5'h11, 5'h05,
      5'h05, 5'h10, 5'h03, 5'h1A, 5'h1A};
   ltd_core i_dut (.*);
   ltd_mem_model i_mem (.*);
   // free-running clock
   initial begin
      forever #50 pclk = ~pclk;
   end
   // count return pulses and nop-cycle clocks seen at the ports
   always @(posedge pclk) begin
      if (ret_req === 1'b1)
         n_ret <= n_ret + 1;
      if (nop_cycle === 1'b1)
         n_nop <= n_nop + 1;
   end
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   // apb transfer, held until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n == 20) begin
         n_fail++;
         give_verdict();
      end
      rv = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input string what,
      input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(what, exp, rv);
   endtask
   // feed w1, then w2; gap counts clocks from w1 taken to w2 taken
   task automatic op(input logic [15:0] w1, input logic [15:0] w2);
      int n;
      @(posedge pclk);
      instr_valid <= 1'b1;
      instr_word <= w1;
      n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (instr_ready !== 1'b1 && n < 20);
      @(posedge pclk);
      instr_word <= w2;
      gap = 0;
      do begin
         @(negedge pclk);
         gap++;
      end while (instr_ready !== 1'b1 && gap < 20);
      @(posedge pclk);
      instr_word <= 16'h0000;
      if (n == 20 || gap == 20) begin
         n_fail++;
         give_verdict();
      end
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rd(`LTD_A_ACC, "acc reset", 32'h0);
      rd(`LTD_A_FLAGS, "flags reset", 32'h0);
      apb(1'b1, 8'h3C, 32'hFFFFFFFF);
      chk("unmapped error", 32'h1, {31'h0, pslverr});
      $display("reset test done");
      for (int i = 0; i < 11; i++) begin
         op(lit_w[i], 16'h0000);
         chk("literal length", 32'h4, gap);
         rd(`LTD_A_ACC, "acc", {24'h0, lit_a[i]});
         rd(`LTD_A_FLAGS, "flags", {27'h0, lit_f[i]});
      end
      rd(`LTD_A_PROD, "product", 32'h180);
      chk("nop clocks", 32'h0, n_nop);
      op(16'h0C44, 16'h0000);
      chk("return length", 32'h8, gap);
      chk("return pulse", 32'h1, n_ret);
      chk("nop clocks", 32'h4, n_nop);
      rd(`LTD_A_ACC, "return acc", 32'h44);
      op(16'h0105, 16'h0000);
      rd(`LTD_A_BANK, "bank", 32'h5);
      rd(`LTD_A_FLAGS, "flags kept", 32'h1A);
      // another decoder asks for a second cycle on a one-cycle op
      ext_two_cycle <= 1'b1;
      op(16'h0E33, 16'h0000);
      ext_two_cycle <= 1'b0;
      chk("forced length", 32'h8, gap);
      rd(`LTD_A_ACC, "forced acc", 32'h33);
      $display("literal test done");
      op(16'hEE1A, 16'hF0BC);
      chk("pointer length", 32'h4, gap);
      // pointer lands at the end of the second cycle, after the word
      repeat (3) @(posedge pclk);
      rd(`LTD_A_PTR1, "pointer", 32'hABC);
      op(16'hF033, 16'h0000);
      chk("lone word length", 32'h4, gap);
      rd(`LTD_A_PTR1, "pointer kept", 32'hABC);
      $display("pointer test done");
      apb(1'b1, `LTD_A_TPTR, 32'h10);
      tp = 22'h10;
      for (int m = 0; m < 8; m++) begin
         if (m == 4) begin
            apb(1'b1, `LTD_A_CTRL, 32'h2);
            apb(1'b1, `LTD_A_TLAT, 32'h5A);
         end
         ta = tp + 22'(m % 4 == 3);
         op(16'h0008 + 16'(m), 16'h0000);
         chk("table length", 32'h8, gap);
         if (m < 4) begin
            rd(`LTD_A_TLAT, "latch", {24'h0, ta[7:0] ^ 8'hA5});
         end else begin
            chk("write addr", {10'h0, ta}, {10'h0, i_mem.wa});
            chk("write data", 32'h5A, {24'h0, i_mem.wd});
         end
         tp = (m % 4 == 0) ? tp : (m % 4 == 2) ? tp - 22'h1 : tp + 22'h1;
         rd(`LTD_A_TPTR, "table pointer", {10'h0, tp});
      end
      slow <= 1'b1;
      op(16'h000C, 16'h0000);
      apb(1'b0, `LTD_A_STAT, 32'h0);
      chk("long write busy", 32'h1, {31'h0, rv[4]});
      for (k = 0; k < 40 && pm_wr_busy !== 1'b0; k++) @(posedge pclk);
      chk("long write ends", 32'h0, {31'h0, pm_wr_busy});
      $display("table test done");
      apb(1'b1, `LTD_A_CTRL, 32'h1);
      port_pins <= 8'h3C;
      rd_addr <= `LTD_PORT_ADDR;
      repeat (4) @(posedge pclk);
      chk("port read", 32'h3C, {24'h0, rd_data});
      rd_addr <= 12'h123;
      repeat (2) @(posedge pclk);
      chk("latch read", 32'h1F, {24'h0, rd_data});
      // the last pass unassigns the prescaler before the timer write
      for (int j = 0; j < 3; j++) begin
         if (j == 2)
            apb(1'b1, `LTD_A_CTRL, 32'h0);
         @(posedge pclk);
         dw_valid <= 1'b1;
         dw_addr <= (j == 1) ? 12'h100 : `LTD_TIMER_ZERO_COUNT_ADDR;
         @(posedge pclk);
         dw_valid <= 1'b0;
         @(negedge pclk);
         chk("prescaler clear", 32'(j == 0), {31'h0, prescaler_clr});
      end
      $display("data test done");
      give_verdict();
   end
endmodule
bind ltd_core ltd_core_chk i_chk (.*);
`default_nettype wire
